// ### include/ssf_regs.svh
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH

// ==========================================================================
// byte framing
`define SSF_BITS_PER_BYTE 8
`define SSF_CNT_LAST 3'h7
`define SSF_CNT_ZERO 3'h0

// ==========================================================================
// status byte bit positions
`define SSF_FLAG_DONE_POS 7
`define SSF_FLAG_WRITE_COLLISION_FLAG_POS 6
`define SSF_FLAG_MODE_FAULT_FLAG_POS 5
`define SSF_FLAG_OVR_POS 4
`define SSF_MODE_HI_POS 3
`define SSF_MODE_LO_POS 2
`define SSF_TX_EMPTY_POS 1
`define SSF_ENABLE_POS 0

// ==========================================================================
// reset values
`define SSF_CTRL_RESET 6'h04
`define SSF_DATA_RESET 8'h00
`define SSF_FLAGS_RESET 4'h0

`endif

// ### include/ssf_pkg.sv
package ssf_pkg;

    // ======================================================================
    // control settings, written as one word
    typedef struct packed {
        logic unit_enable;
        logic master_enable;
        logic select_mode_hi;
        logic select_mode_lo;
        logic clock_polarity;
        logic clock_phase;
    } ssf_ctrl_t;

    // ======================================================================
    // sticky event flags
    typedef struct packed {
        logic transfer_done_flag;
        logic write_collision_flag;
        logic mode_fault_flag;
        logic receive_overrun_flag;
    } ssf_flags_t;

    // ======================================================================
    // received byte handed from the link domain with its event toggle
    typedef struct packed {
        logic done_tgl;
        logic [7:0] word;
    } ssf_rx_t;

    // ======================================================================
    // operating role decoded from the control word
    typedef enum logic [1:0] {
        SSF_ROLE_OFF,
        SSF_ROLE_SLAVE3,
        SSF_ROLE_SLAVE4,
        SSF_ROLE_MASTER
    } ssf_role_t;

endpackage : ssf_pkg

// ### design/ssf_link.sv
`timescale 1ns/10ps
`include "ssf_regs.svh"

module ssf_link (
    // serial pins
    input wire logic sck_in,
    input wire logic mosi_in,
    output logic miso_out,
    // configuration, static while selected
    input wire logic clock_polarity_in,
    input wire logic clock_phase_in,
    // resets from the system side
    input wire logic cnt_rstn_in,
    input wire logic en_rstn_in,
    // words crossing the domains
    input wire logic [7:0] tx_word_in,
    output ssf_pkg::ssf_rx_t rx_out
);
    import ssf_pkg::*;

    logic samp_clk;
    logic [2:0] cnt_q;
    logic [6:0] sh_q;
    logic miso_q;
    logic tgl_q;
    logic [7:0] rx_word_q;

    // ======================================================================
    // edge selection: sampling edge becomes the rising edge of samp_clk
    assign samp_clk = sck_in ^ clock_polarity_in ^ clock_phase_in;

    // ======================================================================
    // bit counter and receive shift; only master edges move it
    always_ff @(posedge samp_clk or negedge cnt_rstn_in) begin
        if (!cnt_rstn_in) begin
            cnt_q <= `SSF_CNT_ZERO;
            sh_q <= 7'h00;
        end else begin
            sh_q <= {sh_q[5:0], mosi_in};
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // ======================================================================
    // completed byte; the toggle survives select changes so no false event
    always_ff @(posedge samp_clk or negedge en_rstn_in) begin
        if (!en_rstn_in) begin
            tgl_q <= 1'b0;
            rx_word_q <= `SSF_DATA_RESET;
        end else if (cnt_q == `SSF_CNT_LAST) begin
            rx_word_q <= {sh_q, mosi_in};
            tgl_q <= ~tgl_q;
        end
    end

    // ======================================================================
    // output bit changes on the opposite edge to sampling
    always_ff @(negedge samp_clk or negedge cnt_rstn_in) begin
        if (!cnt_rstn_in) begin
            miso_q <= 1'b0;
        end else begin
            miso_q <= tx_word_in[3'h7 - cnt_q];
        end
    end

    // with phase 0 the first bit must stand before any clock edge
    assign miso_out = (cnt_q == `SSF_CNT_ZERO && !clock_phase_in) ? tx_word_in[7] : miso_q;
    assign rx_out.done_tgl = tgl_q;
    assign rx_out.word = rx_word_q;

    // ======================================================================
    // checks
    property p_byte_wrap;
        @(posedge samp_clk) disable iff (!cnt_rstn_in)
        cnt_q == `SSF_CNT_LAST |=> cnt_q == `SSF_CNT_ZERO && tgl_q != $past(tgl_q);
    endproperty
    a_byte_wrap: assert property (p_byte_wrap) else $error("byte not closed after 8 bits");

endmodule : ssf_link

// ### design/ssf_slave.sv
`timescale 1ns/10ps
`include "ssf_regs.svh"

module ssf_slave #(
    parameter int SYNC_STAGES = 2
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // serial pins
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic slave_select_n_in,
    output logic miso_out,
    output logic miso_oe_out,
    // control
    input wire logic ctrl_wr_in,
    input wire ssf_pkg::ssf_ctrl_t ctrl_in,
    input wire ssf_pkg::ssf_flags_t flag_clr_in,
    input wire logic int_en_in,
    // data port
    input wire logic data_wr_in,
    input wire logic [7:0] data_wdata_in,
    input wire logic data_rd_in,
    output logic [7:0] data_rdata_out,
    // status
    output ssf_pkg::ssf_ctrl_t ctrl_out,
    output logic [7:0] status_out,
    output logic irq_out
);
    import ssf_pkg::*;

    ssf_ctrl_t ctrl_q;
    ssf_flags_t flags_q;
    ssf_role_t role;
    ssf_rx_t link_rx;
    logic [SYNC_STAGES-1:0] ss_pipe_q;
    logic ss_n_sync;
    logic [SYNC_STAGES-1:0] tg_pipe_q;
    logic tg_seen_q;
    logic done_pulse;
    logic slave_on;
    logic cnt_rstn;
    logic en_rstn;
    logic mode_fault_flag_evt;
    logic write_collision_flag_evt;
    logic ovr_evt;
    logic wr_ok;
    logic move;
    logic [7:0] tx_buf_q;
    logic tx_buf_full_q;
    logic [7:0] tx_word_q;
    logic sh_full_q;
    logic [7:0] rx_buf_q;
    logic rx_full_q;

    // ======================================================================
    // role decode
    always_comb begin
        role = SSF_ROLE_OFF;
        if (ctrl_q.unit_enable) begin
            if (ctrl_q.master_enable) begin
                role = SSF_ROLE_MASTER;
            end else begin
                // select driven as an output makes the pin useless to a slave
                unique case ({ctrl_q.select_mode_hi, ctrl_q.select_mode_lo})
                    2'b00: role = SSF_ROLE_SLAVE3;
                    2'b01: role = SSF_ROLE_SLAVE4;
                    2'b10: role = SSF_ROLE_SLAVE3;
                    2'b11: role = SSF_ROLE_SLAVE3;
                endcase
            end
        end
    end

    assign slave_on = (role == SSF_ROLE_SLAVE3) || (role == SSF_ROLE_SLAVE4);

    // ======================================================================
    // select synchroniser; its two cycles fit within the master's three-clock setup margin
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            ss_pipe_q <= '1;
        end else begin
            ss_pipe_q <= {ss_pipe_q[SYNC_STAGES-2:0], slave_select_n_in};
        end
    end

    assign ss_n_sync = ss_pipe_q[SYNC_STAGES-1];

    // ======================================================================
    // link resets: select high holds the counter at zero in four-wire,
    // so each falling edge starts a fresh byte; three-wire follows enable only
    assign en_rstn = slave_on;
    assign cnt_rstn = (role == SSF_ROLE_SLAVE3) ||
                      (role == SSF_ROLE_SLAVE4 && !ss_n_sync);

    // ======================================================================
    // link domain
    ssf_link u_link (
        .sck_in(sck_in),
        .mosi_in(mosi_in),
        .miso_out(miso_out),
        .clock_polarity_in(ctrl_q.clock_polarity),
        .clock_phase_in(ctrl_q.clock_phase),
        .cnt_rstn_in(cnt_rstn),
        .en_rstn_in(en_rstn),
        .tx_word_in(tx_word_q),
        .rx_out(link_rx)
    );

    // the slave only answers; it drives the bus always in three-wire, and in four-wire only while selected
    assign miso_oe_out = cnt_rstn;

    // ======================================================================
    // byte-done toggle crossing; received word is stable for a whole byte
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in || !slave_on) begin
            tg_pipe_q <= '0;
            tg_seen_q <= 1'b0;
        end else begin
            tg_pipe_q <= {tg_pipe_q[SYNC_STAGES-2:0], link_rx.done_tgl};
            tg_seen_q <= tg_pipe_q[SYNC_STAGES-1];
        end
    end

    assign done_pulse = tg_pipe_q[SYNC_STAGES-1] ^ tg_seen_q;

    // ======================================================================
    // event decode
    // only the input-select setting lets another master pull select low
    assign mode_fault_flag_evt = (role == SSF_ROLE_MASTER) && !ctrl_q.select_mode_hi &&
                      ctrl_q.select_mode_lo && !ss_n_sync;
    assign write_collision_flag_evt = data_wr_in && tx_buf_full_q;
    assign wr_ok = data_wr_in && !tx_buf_full_q;
    assign ovr_evt = done_pulse && rx_full_q;
    assign move = tx_buf_full_q && !sh_full_q;

    // ======================================================================
    // control word; a mode fault overrides a same-cycle write
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            ctrl_q <= `SSF_CTRL_RESET;
        end else if (mode_fault_flag_evt) begin
            ctrl_q.unit_enable <= 1'b0;
            ctrl_q.master_enable <= 1'b0;
        end else if (ctrl_wr_in) begin
            ctrl_q <= ctrl_in;
        end
    end

    // ======================================================================
    // transmit buffer
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            tx_buf_q <= `SSF_DATA_RESET;
            tx_buf_full_q <= 1'b0;
        end else if (wr_ok) begin
            tx_buf_q <= data_wdata_in;
            tx_buf_full_q <= 1'b1;
        end else if (move) begin
            tx_buf_full_q <= 1'b0;
        end
    end

    // ======================================================================
    // shift-register word seen by the link; a move while a byte is on the
    // wire corrupts that byte, software waits for the done flag to avoid it
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            tx_word_q <= `SSF_DATA_RESET;
            sh_full_q <= 1'b0;
        end else if (move) begin
            tx_word_q <= tx_buf_q;
            sh_full_q <= 1'b1;
        end else if (done_pulse) begin
            sh_full_q <= 1'b0;
        end
    end

    // ======================================================================
    // receive buffer; an unread byte is kept and the new one dropped
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            rx_buf_q <= `SSF_DATA_RESET;
            rx_full_q <= 1'b0;
        end else if (done_pulse && !rx_full_q) begin
            rx_buf_q <= link_rx.word;
            rx_full_q <= 1'b1;
        end else if (data_rd_in) begin
            rx_full_q <= 1'b0;
        end
    end

    assign data_rdata_out = rx_buf_q;

    // ======================================================================
    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            flags_q <= `SSF_FLAGS_RESET;
        end else begin
            flags_q.transfer_done_flag <= done_pulse ||
                (flags_q.transfer_done_flag && !flag_clr_in.transfer_done_flag);
            flags_q.write_collision_flag <= write_collision_flag_evt ||
                (flags_q.write_collision_flag && !flag_clr_in.write_collision_flag);
            flags_q.mode_fault_flag <= mode_fault_flag_evt ||
                (flags_q.mode_fault_flag && !flag_clr_in.mode_fault_flag);
            flags_q.receive_overrun_flag <= ovr_evt ||
                (flags_q.receive_overrun_flag && !flag_clr_in.receive_overrun_flag);
        end
    end

    // ======================================================================
    // outputs
    assign irq_out = int_en_in && (|flags_q);
    assign ctrl_out = ctrl_q;

    always_comb begin
        status_out = 8'h00;
        status_out[`SSF_FLAG_DONE_POS] = flags_q.transfer_done_flag;
        status_out[`SSF_FLAG_WRITE_COLLISION_FLAG_POS] = flags_q.write_collision_flag;
        status_out[`SSF_FLAG_MODE_FAULT_FLAG_POS] = flags_q.mode_fault_flag;
        status_out[`SSF_FLAG_OVR_POS] = flags_q.receive_overrun_flag;
        status_out[`SSF_MODE_HI_POS] = ctrl_q.select_mode_hi;
        status_out[`SSF_MODE_LO_POS] = ctrl_q.select_mode_lo;
        status_out[`SSF_TX_EMPTY_POS] = !tx_buf_full_q;
        status_out[`SSF_ENABLE_POS] = ctrl_q.unit_enable;
    end

    // ======================================================================
    // checks
    default clocking cb_sys @(posedge clk_sys_in);
    endclocking

    default disable iff (!rstn_in);

    sequence s_write_accepted;
        data_wr_in && !tx_buf_full_q && !sh_full_q;
    endsequence

    sequence s_reload_pending;
        tx_buf_full_q && sh_full_q && done_pulse;
    endsequence

    property p_done_sets;
        done_pulse |=> flags_q.transfer_done_flag;
    endproperty
    a_done_sets: assert property (p_done_sets) else $error("done flag not set");

    property p_rx_copy;
        done_pulse && !rx_full_q |=> rx_buf_q == $past(link_rx.word) && rx_full_q;
    endproperty
    a_rx_copy: assert property (p_rx_copy) else $error("byte not copied to buffer");

    property p_overrun;
        done_pulse && rx_full_q |=> flags_q.receive_overrun_flag && $stable(rx_buf_q);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun mishandled");

    property p_collision;
        data_wr_in && tx_buf_full_q |=> flags_q.write_collision_flag && $stable(tx_buf_q);
    endproperty
    a_collision: assert property (p_collision) else $error("collision mishandled");

    property p_move_now;
        s_write_accepted |=> ##1 sh_full_q && tx_word_q == $past(data_wdata_in, 2);
    endproperty
    a_move_now: assert property (p_move_now) else $error("write not moved to shifter");

    property p_reload_after;
        s_reload_pending |=> !sh_full_q ##1 sh_full_q && !tx_buf_full_q;
    endproperty
    a_reload_after: assert property (p_reload_after) else $error("no reload after byte");

    property p_mode_fault;
        mode_fault_flag_evt |=> flags_q.mode_fault_flag && !ctrl_q.unit_enable && !ctrl_q.master_enable;
    endproperty
    a_mode_fault: assert property (p_mode_fault) else $error("mode fault not handled");

    property p_hold_done;
        flags_q.transfer_done_flag && !flag_clr_in.transfer_done_flag
            |=> flags_q.transfer_done_flag;
    endproperty
    a_hold_done: assert property (p_hold_done) else $error("done flag lost");

    property p_irq;
        irq_out == (int_en_in && (flags_q != `SSF_FLAGS_RESET));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request wrong");

    property p_read_frees;
        data_rd_in && !done_pulse |=> !rx_full_q;
    endproperty
    a_read_frees: assert property (p_read_frees) else $error("read did not free buffer");

    property p_four_wire_idle;
        role == SSF_ROLE_SLAVE4 && ss_n_sync |-> !miso_oe_out && !cnt_rstn;
    endproperty
    a_four_wire_idle: assert property (p_four_wire_idle) else $error("active while deselected");

    property p_three_wire;
        role == SSF_ROLE_SLAVE3 |-> cnt_rstn && miso_oe_out;
    endproperty
    a_three_wire: assert property (p_three_wire) else $error("three-wire used select");

    property p_default_mode;
        ctrl_q.unit_enable && !ctrl_q.master_enable && !ctrl_q.select_mode_hi &&
            ctrl_q.select_mode_lo |-> role == SSF_ROLE_SLAVE4;
    endproperty
    a_default_mode: assert property (p_default_mode) else $error("four-wire decode wrong");

    property p_master_quiet;
        role == SSF_ROLE_MASTER |-> !miso_oe_out && !slave_on;
    endproperty
    a_master_quiet: assert property (p_master_quiet) else $error("slave active as master");

endmodule : ssf_slave

// ### testbench/ssf_spi_master.sv
`timescale 1ns/10ps

// ==========================================================================
// far-side serial master: clock still outside frames, data line flipped after each frame
module ssf_spi_master (
    // serial pins
    output logic sck_out,
    output logic mosi_out,
    output logic ss_n_out,
    input wire logic miso_in
);
    initial begin
        sck_out = 1'b0;
        mosi_out = 1'b0;
        ss_n_out = 1'b1;
    end

    // ======================================================================
    // select control, used alone for the three-wire select pulse and the fault case
    task automatic set_select(input logic lvl);
        ss_n_out = lvl;
    endtask : set_select

    // ======================================================================
    // one frame of nbits, msb first; sck 6 ns period
    task automatic xfer(input logic [7:0] tx, input int nbits, input logic cpol,
                        input logic cpha, input logic use_ss, output logic [7:0] rx);
        int i;
        rx = 8'h00;
        sck_out = cpol;
        if (use_ss) begin
            ss_n_out = 1'b0;
            #30; // three system clocks, margin over two
        end
        for (i = 0; i < nbits; i++) begin
            if (cpha) begin
                sck_out = ~cpol;
            end
            mosi_out = tx[7 - i];
            #3;
            sck_out = cpha ? cpol : ~cpol;
            rx = {rx[6:0], miso_in};
            #3;
            if (!cpha) begin
                sck_out = cpol;
            end
        end
        #20;
        // only this master selects, so a lone slave is assumed
        if (use_ss) begin
            ss_n_out = 1'b1;
        end
        mosi_out = ~mosi_out;
        // hold select high long enough for the synchroniser to end the frame
        if (use_ss) begin
            #30;
        end
    endtask : xfer
endmodule : ssf_spi_master

// ### testbench/ssf_slave_test.sv
`timescale 1ns/10ps

module ssf_slave_test;
    import ssf_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic sck, mosi, ss_n, miso_line, miso_out, miso_oe_out, irq_out;
    logic ctrl_wr_in = 1'b0;
    ssf_ctrl_t ctrl_in = '0;
    ssf_flags_t flag_clr_in = '0;
    logic int_en_in = 1'b0;
    logic data_wr_in = 1'b0;
    logic [7:0] data_wdata_in = 8'h00;
    logic data_rd_in = 1'b0;
    logic [7:0] data_rdata_out, status_out, got, s, mb;
    ssf_ctrl_t ctrl_out;
    logic [1:0] mm;
    int miscompares = 0;
    int checks = 0;
    int m;

    always #5 clk_sys_in = ~clk_sys_in;
    // weak pull-up on the data line while the slave lets go
    assign miso_line = miso_oe_out ? miso_out : 1'b1;

    ssf_spi_master u_ssf_spi_master (.sck_out(sck), .mosi_out(mosi), .ss_n_out(ss_n),
        .miso_in(miso_line));

    ssf_slave u_ssf_slave (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .sck_in(sck),
        .mosi_in(mosi), .slave_select_n_in(ss_n), .miso_out(miso_out),
        .miso_oe_out(miso_oe_out), .ctrl_wr_in(ctrl_wr_in), .ctrl_in(ctrl_in),
        .flag_clr_in(flag_clr_in), .int_en_in(int_en_in), .data_wr_in(data_wr_in),
        .data_wdata_in(data_wdata_in), .data_rd_in(data_rd_in),
        .data_rdata_out(data_rdata_out), .ctrl_out(ctrl_out), .status_out(status_out),
        .irq_out(irq_out));

    // ======================================================================
    // expectations and checks
    function automatic logic exp_irq(input logic [3:0] flags, input logic en);
        return en & (|flags);
    endfunction : exp_irq

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // ======================================================================
    // port drivers, all on the falling edge
    task automatic set_ctrl(input logic [5:0] c);
        @(negedge clk_sys_in);
        ctrl_in = c;
        ctrl_wr_in = 1'b1;
        @(negedge clk_sys_in);
        ctrl_wr_in = 1'b0;
    endtask : set_ctrl

    task automatic wr_data(input logic [7:0] b);
        @(negedge clk_sys_in);
        data_wdata_in = b;
        data_wr_in = 1'b1;
        @(negedge clk_sys_in);
        data_wr_in = 1'b0;
    endtask : wr_data

    task automatic rd_clr();
        @(negedge clk_sys_in);
        data_rd_in = 1'b1;
        flag_clr_in = 4'hF;
        @(negedge clk_sys_in);
        data_rd_in = 1'b0;
        flag_clr_in = 4'h0;
    endtask : rd_clr

    // done lands a few clocks after the last edge; bounded wait
    task automatic wait_done();
        int n;
        n = 0;
        while (status_out[7] !== 1'b1 && n < 40) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk("done flag", 8'h01, {7'h00, status_out[7]});
    endtask : wait_done

    initial begin
        #300000;
        miscompares++;
        give_verdict();
    end

    // ======================================================================
    // main sequence
    initial begin
        void'($urandom(32'hf10390aa));
        repeat (12) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        chk("status reset", 8'h06, status_out);
        chk("control reset", 8'h04, {2'b00, ctrl_out});
        // descending so the clock idles low at the end
        for (m = 3; m >= 0; m--) begin
            mm = 2'(m);
            s = 8'($urandom);
            mb = 8'($urandom);
            int_en_in = 1'($urandom);
            set_ctrl({4'b1001, mm});
            wr_data(s);
            repeat (2) @(negedge clk_sys_in);
            chk("tx moved", 8'h01, {7'h00, status_out[1]});
            u_ssf_spi_master.xfer(mb, 8, mm[1], mm[0], 1'b1, got);
            chk("miso byte", s, got);
            wait_done();
            chk("rx buffer", mb, data_rdata_out);
            chk("irq", {7'h00, exp_irq(4'h8, int_en_in)}, {7'h00, irq_out});
            rd_clr();
        end
        // busy shifter, collision, reload and overrun
        int_en_in = 1'b1;
        wr_data(8'hA5);
        repeat (2) @(negedge clk_sys_in);
        wr_data(8'h3C);
        wr_data(8'hC3);
        repeat (2) @(negedge clk_sys_in);
        chk("collision flag", 8'h01, {7'h00, status_out[6]});
        u_ssf_spi_master.xfer(8'h11, 8, 1'b0, 1'b0, 1'b1, got);
        chk("first out", 8'hA5, got);
        wait_done();
        u_ssf_spi_master.xfer(8'h22, 8, 1'b0, 1'b0, 1'b1, got);
        chk("reloaded out", 8'h3C, got);
        repeat (20) @(negedge clk_sys_in);
        chk("sticky flags", 8'h0D, {4'h0, status_out[7:4]});
        chk("old byte kept", 8'h11, data_rdata_out);
        chk("irq set", 8'h01, {7'h00, irq_out});
        rd_clr();
        chk("irq clear", 8'h00, {7'h00, irq_out});
        // clock with select high, then a cut frame
        u_ssf_spi_master.xfer(8'h5A, 8, 1'b0, 1'b0, 1'b0, got);
        repeat (10) @(negedge clk_sys_in);
        chk("no done unselected", 8'h00, {7'h00, status_out[7]});
        chk("miso released", 8'h00, {7'h00, miso_oe_out});
        u_ssf_spi_master.xfer(8'hFF, 3, 1'b0, 1'b0, 1'b1, got);
        mb = 8'($urandom);
        u_ssf_spi_master.xfer(mb, 8, 1'b0, 1'b0, 1'b1, got);
        wait_done();
        chk("rx after cut", mb, data_rdata_out);
        rd_clr();
        // three-wire: select ignored, counter kept across select pulses
        set_ctrl(6'b100000);
        chk("three wire drive", 8'h01, {7'h00, miso_oe_out});
        u_ssf_spi_master.xfer(8'hB4, 5, 1'b0, 1'b0, 1'b0, got);
        u_ssf_spi_master.set_select(1'b0);
        repeat (4) @(negedge clk_sys_in);
        u_ssf_spi_master.set_select(1'b1);
        u_ssf_spi_master.xfer(8'h60, 3, 1'b0, 1'b0, 1'b0, got);
        wait_done();
        chk("joined byte", 8'hB3, data_rdata_out);
        rd_clr();
        u_ssf_spi_master.xfer(8'h0F, 5, 1'b0, 1'b0, 1'b0, got);
        set_ctrl(6'b000000);
        set_ctrl(6'b100000);
        mb = 8'($urandom);
        u_ssf_spi_master.xfer(mb, 8, 1'b0, 1'b0, 1'b0, got);
        wait_done();
        chk("rx after re-enable", mb, data_rdata_out);
        rd_clr();
        // upper mode bit set as slave behaves like three-wire
        set_ctrl(6'b101000);
        chk("mode hi drive", 8'h01, {7'h00, miso_oe_out});
        chk("mode hi status", 8'h0B, status_out);
        // master with select pulled low, select used as an input
        set_ctrl(6'b110100);
        u_ssf_spi_master.set_select(1'b0);
        repeat (6) @(negedge clk_sys_in);
        chk("mode fault", 8'h01, {7'h00, status_out[5]});
        chk("enables off", 8'h00, {6'h00, ctrl_out[5:4]});
        u_ssf_spi_master.set_select(1'b1);
        give_verdict();
    end
endmodule : ssf_slave_test
